// ==== core/fpa_pkg.sv ====
// constants and carrier types for the fire panel status annunciator
package fpa_pkg;
   // ==========================================================
   // clock and flash timing
   localparam int CLK_MHZ = 250;
   localparam int TICK_MS = 50;
   localparam int TICK_CYC = TICK_MS * CLK_MHZ * 1000;
   localparam int SLOW_PERIOD_MS = 2000;
   localparam int NORM_PERIOD_MS = 500;
   localparam int RAPID_TOGGLES_PER_S = 10;
   localparam int FAIL_HOLD_MS = 60000;
   localparam int SLOW_TICKS = SLOW_PERIOD_MS / TICK_MS;
   localparam int NORM_TICKS = NORM_PERIOD_MS / TICK_MS;
   localparam int RAPID_TICKS = 1000 / RAPID_TOGGLES_PER_S / TICK_MS;
   localparam int FAIL_HOLD_TICKS = FAIL_HOLD_MS / TICK_MS;
   localparam int NUM_ZONES = 8;

   // ==========================================================
   // register map (byte addresses) and fields
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_ISO_LIMIT = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam int CFG_MAF_ONLY = 0;
   localparam int CFG_SND_DIS = 1;
   localparam int CFG_DISC_MON = 2;
   localparam logic [2:0] CFG_RESET = 3'h5;
   localparam logic [7:0] ISO_LIMIT_RESET = 8'hFF;
   localparam int ST_LEDS = 0;
   localparam int ST_FAULT_SND = 7;
   localparam int ST_FAULT_TEXT = 8;
   localparam int ST_ALARM_SND = 9;
   localparam int ST_BATT_RUN = 10;
   localparam int ST_BATT_FAIL = 11;

   // ==========================================================
   // carriers
   typedef enum logic [2:0] {
      PAT_OFF, PAT_ON, PAT_SLOW, PAT_NORM, PAT_RAPID
   } fpa_pat_type;

   typedef struct packed {
      logic tick;
      logic slow;
      logic norm;
      logic rapid;
   } fpa_flash_type;

   typedef struct packed {
      logic bells;
      logic sysflt;
      logic chgr;
      logic mains;
      logic isolate;
      logic fault;
      logic alarm;
   } fpa_leds_type;
endpackage : fpa_pkg

// ==== core/fpa_flash_gen.sv ====
// free-running flash timebase shared by every indicator except the mains led
`timescale 1ns/1ps
module fpa_flash_gen #(
   parameter int unsigned TICK_CYC = fpa_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // patterns
   output fpa_pkg::fpa_flash_type flash_o
);
   localparam int PW = $clog2(TICK_CYC);

   typedef struct packed {
      logic [PW-1:0] pre;
      logic [5:0] slow_cnt;
      logic [3:0] norm_cnt;
      fpa_pkg::fpa_flash_type fl;
   } fpa_fg_state_type;

   fpa_fg_state_type st_reg, st_next;
   logic tick;

   // ==========================================================
   // one prescaler and two tick counters, so same patterns stay in phase
   assign tick = (st_reg.pre == PW'(TICK_CYC - 1));

   always_comb begin
      st_next = st_reg;
      st_next.fl.tick = tick;
      if (tick) begin
         st_next.pre = '0;
         if (st_reg.slow_cnt == 6'(fpa_pkg::SLOW_TICKS - 1)) begin
            st_next.slow_cnt = '0;
         end else begin
            st_next.slow_cnt = st_reg.slow_cnt + 6'h01;
         end
         if (st_reg.norm_cnt == 4'(fpa_pkg::NORM_TICKS - 1)) begin
            st_next.norm_cnt = '0;
         end else begin
            st_next.norm_cnt = st_reg.norm_cnt + 4'h1;
         end
      end else begin
         st_next.pre = st_reg.pre + PW'(1);
      end
      // on for the first half of each period
      st_next.fl.slow = (st_next.slow_cnt < 6'(fpa_pkg::SLOW_TICKS / 2));
      st_next.fl.norm = (st_next.norm_cnt < 4'(fpa_pkg::NORM_TICKS / 2));
      // slow period is a multiple of the rapid period, so rapid wraps cleanly
      st_next.fl.rapid = ((st_next.slow_cnt / 6'(fpa_pkg::RAPID_TICKS)) % 6'h02) == 6'h00;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   assign flash_o = st_reg.fl;
endmodule : fpa_flash_gen

// ==== core/fpa_batt_test.sv ====
// battery test tracker: running, failed and the failure hold window
`timescale 1ns/1ps
module fpa_batt_test #(
   parameter int unsigned HOLD_TICKS = fpa_pkg::FAIL_HOLD_TICKS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic tick_i,
   // test events
   input wire logic start_i,
   input wire logic done_i,
   input wire logic pass_i,
   // state
   output logic running_o,
   output logic failed_o
);
   typedef enum logic [1:0] {BT_IDLE, BT_RUN, BT_FAIL} fpa_bt_state_type;

   typedef struct packed {
      fpa_bt_state_type fsm;
      logic [15:0] hold;
   } fpa_bt_type;

   fpa_bt_type st_reg, st_next;

   // ==========================================================
   // a failure shows for at most the hold window, then live state returns
   always_comb begin
      st_next = st_reg;
      unique case (st_reg.fsm)
         BT_IDLE: begin
            if (start_i) begin
               st_next.fsm = BT_RUN;
            end
         end
         BT_RUN: begin
            if (done_i) begin
               st_next.fsm = pass_i ? BT_IDLE : BT_FAIL;
               st_next.hold = '0;
            end
         end
         BT_FAIL: begin
            if (start_i) begin
               st_next.fsm = BT_RUN;
            end else if (tick_i) begin
               if (st_reg.hold == 16'(HOLD_TICKS - 1)) begin
                  st_next.fsm = BT_IDLE;
               end else begin
                  st_next.hold = st_reg.hold + 16'h0001;
               end
            end
         end
         default: st_next.fsm = BT_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '{fsm: BT_IDLE, hold: 16'h0000};
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   assign running_o = (st_reg.fsm == BT_RUN);
   assign failed_o = (st_reg.fsm == BT_FAIL);
endmodule : fpa_batt_test

// ==== core/fpa_annunciator.sv ====
// fire panel status annunciator: system leds, fault sounder, keypad reactions
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module fpa_annunciator #(
   parameter int unsigned NZ = fpa_pkg::NUM_ZONES,
   parameter int unsigned TICK_CYC = fpa_pkg::TICK_CYC,
   parameter int unsigned HOLD_TICKS = fpa_pkg::FAIL_HOLD_TICKS
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // zone status
   input wire logic [NZ-1:0] zone_alarm_i,
   input wire logic [NZ-1:0] zone_master_alarm_group_i,
   input wire logic [NZ-1:0] zone_fault_i,
   input wire logic [NZ-1:0] zone_isolated_i,
   input wire logic point_isolated_i,
   // alarm list status
   input wire logic list_unack_i,
   input wire logic group_unplaced_unack_i,
   // power and battery
   input wire logic mains_ok_i,
   input wire logic charger_fault_i,
   input wire logic batt_low_i,
   input wire logic batt_disconnected_i,
   input wire logic batt_test_start_i,
   input wire logic batt_test_done_i,
   input wire logic batt_test_pass_i,
   // system and bells
   input wire logic system_fault_i,
   input wire logic db_download_i,
   input wire logic bells_local_iso_i,
   input wire logic bells_remote_silenced_i,
   input wire logic bells_ext_silenced_i,
   // keypad
   input wire logic key_base_display_i,
   input wire logic key_clear_i,
   input wire logic key_ack_i,
   input wire logic key_next_i,
   // indicators and sounders
   output fpa_pkg::fpa_leds_type leds_o,
   output logic fault_sounder_o,
   output logic alarm_sounder_o,
   output logic fault_text_o,
   output logic alarm_next_o
);
   // fault vector width: every zone plus battery low, system and charger
   localparam int FV = NZ + 3;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [2:0] cfg;
      logic [7:0] iso_limit;
      logic [FV-1:0] fault_prev;
      logic unack_prev;
      logic fault_snd;
      logic fault_text;
      logic alarm_sil;
      logic next_pulse;
      fpa_pkg::fpa_leds_type leds;
   } fpa_main_type;

   fpa_main_type st_reg, st_next;
   fpa_pkg::fpa_flash_type flash;
   fpa_pkg::fpa_pat_type pat_alarm, pat_fault, pat_iso, pat_chgr;
   fpa_pkg::fpa_pat_type pat_sys, pat_bells;
   // battery test state from the tracker
   logic batt_running, batt_failed;
   logic [NZ-1:0] iso_in_range;
   logic [FV-1:0] fault_vec;
   logic new_fault, silence_key, bus_req, any_alarm;

   // ==========================================================
   // shared flash timebase
   fpa_flash_gen #(
      .TICK_CYC(TICK_CYC)
   ) u_flash (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .flash_o(flash)
   );

   // ==========================================================
   // battery test tracking
   fpa_batt_test #(
      .HOLD_TICKS(HOLD_TICKS)
   ) u_batt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .tick_i(flash.tick),
      .start_i(batt_test_start_i),
      .done_i(batt_test_done_i),
      .pass_i(batt_test_pass_i),
      .running_o(batt_running),
      .failed_o(batt_failed)
   );

   // ==========================================================
   // pattern to led level
   function automatic logic pat_level(input fpa_pkg::fpa_pat_type p,
                                      input fpa_pkg::fpa_flash_type fl);
      logic lvl;
      lvl = 1'b0;
      unique case (p)
         fpa_pkg::PAT_OFF: lvl = 1'b0;
         fpa_pkg::PAT_ON: lvl = 1'b1;
         fpa_pkg::PAT_SLOW: lvl = fl.slow;
         fpa_pkg::PAT_NORM: lvl = fl.norm;
         fpa_pkg::PAT_RAPID: lvl = fl.rapid;
         default: lvl = 1'b0;
      endcase
      return lvl;
   endfunction : pat_level

   // ==========================================================
   // zone qualification, one term per zone
   for (genvar z = 0; z < NZ; z++) begin : g_zone
      assign iso_in_range[z] = zone_isolated_i[z] &&
                               (32'(z + 1) <= {24'h000000, st_reg.iso_limit});
   end

   // alarm ignores isolation; group filter only when configured
   assign any_alarm = st_reg.cfg[fpa_pkg::CFG_MAF_ONLY] ?
                      |(zone_alarm_i & zone_master_alarm_group_i) :
                      |zone_alarm_i;

   // ==========================================================
   // led pattern selection, flashing checked before steady
   always_comb begin
      // alarm
      if (list_unack_i || group_unplaced_unack_i) begin
         pat_alarm = fpa_pkg::PAT_NORM;
      end else if (any_alarm) begin
         pat_alarm = fpa_pkg::PAT_ON;
      end else begin
         pat_alarm = fpa_pkg::PAT_OFF;
      end
      // zone fault, isolation not considered
      pat_fault = (|zone_fault_i) ? fpa_pkg::PAT_ON : fpa_pkg::PAT_OFF;
      // isolate
      if (point_isolated_i) begin
         pat_iso = fpa_pkg::PAT_NORM;
      end else if (|iso_in_range) begin
         pat_iso = fpa_pkg::PAT_ON;
      end else begin
         pat_iso = fpa_pkg::PAT_OFF;
      end
      // charger and battery; mains loss alone is not an input here
      if (batt_running) begin
         pat_chgr = fpa_pkg::PAT_RAPID;
      end else if (batt_low_i || batt_failed ||
                   (batt_disconnected_i && st_reg.cfg[fpa_pkg::CFG_DISC_MON])) begin
         pat_chgr = fpa_pkg::PAT_NORM;
      end else if (charger_fault_i) begin
         pat_chgr = fpa_pkg::PAT_ON;
      end else begin
         pat_chgr = fpa_pkg::PAT_OFF;
      end
      // system fault
      if (db_download_i) begin
         pat_sys = fpa_pkg::PAT_SLOW;
      end else if (system_fault_i) begin
         pat_sys = fpa_pkg::PAT_ON;
      end else begin
         pat_sys = fpa_pkg::PAT_OFF;
      end
      // bells: local external switch, then remote, then local isolate
      if (bells_ext_silenced_i) begin
         pat_bells = fpa_pkg::PAT_NORM;
      end else if (bells_remote_silenced_i) begin
         pat_bells = fpa_pkg::PAT_SLOW;
      end else if (bells_local_iso_i) begin
         pat_bells = fpa_pkg::PAT_ON;
      end else begin
         pat_bells = fpa_pkg::PAT_OFF;
      end
   end

   // ==========================================================
   // fault events: any zone, battery low, system or charger fault that newly appears
   assign fault_vec = {charger_fault_i, system_fault_i, batt_low_i, zone_fault_i};
   assign new_fault = |(fault_vec & ~st_reg.fault_prev);
   assign silence_key = key_clear_i || key_ack_i;
   assign bus_req = wb_cyc_i && wb_stb_i;

   // ==========================================================
   // next state: bus slave, sounders, text, led registers
   always_comb begin
      st_next = st_reg;
      // previous samples for edge detection; reset to zero, so a fault
      // already present at release counts as new and sounds at once
      st_next.fault_prev = fault_vec;
      st_next.unack_prev = list_unack_i;
      st_next.next_pulse = key_next_i;

      // fault sounder: a fresh fault wins over a same-cycle silence
      if (new_fault && !st_reg.cfg[fpa_pkg::CFG_SND_DIS]) begin
         st_next.fault_snd = 1'b1;
      end else if (silence_key) begin
         st_next.fault_snd = 1'b0;
      end
      if (st_reg.cfg[fpa_pkg::CFG_SND_DIS]) begin
         st_next.fault_snd = 1'b0;
      end

      // fault text leaves together with the sounder silence
      if (new_fault && key_base_display_i) begin
         st_next.fault_text = 1'b1;
      end else if (silence_key) begin
         st_next.fault_text = 1'b0;
      end

      // internal alarm sounder silenced by next, re-armed by a new alarm
      if (list_unack_i && !st_reg.unack_prev) begin
         st_next.alarm_sil = 1'b0;
      end else if (key_next_i) begin
         st_next.alarm_sil = 1'b1;
      end

      // led levels sampled from the same flash phase, except mains, which follows mains_ok_i
      st_next.leds.alarm = pat_level(pat_alarm, flash);
      st_next.leds.fault = pat_level(pat_fault, flash);
      st_next.leds.isolate = pat_level(pat_iso, flash);
      st_next.leds.mains = mains_ok_i;
      st_next.leds.chgr = pat_level(pat_chgr, flash);
      st_next.leds.sysflt = pat_level(pat_sys, flash);
      st_next.leds.bells = pat_level(pat_bells, flash);

      // wishbone: ack one cycle after the strobe, dropped the next cycle
      // ack blocks a take only in the ack cycle, so a held request is served again every second cycle
      st_next.ack = bus_req && !st_reg.ack;
      if (bus_req && !st_reg.ack) begin
         st_next.rdata = 32'h00000000;
         if (wb_we_i) begin
            unique case (wb_adr_i)
               fpa_pkg::REG_CFG: begin
                  if (wb_sel_i[0]) begin
                     st_next.cfg = wb_dat_i[2:0];
                  end
               end
               fpa_pkg::REG_ISO_LIMIT: begin
                  if (wb_sel_i[0]) begin
                     st_next.iso_limit = wb_dat_i[7:0];
                  end
               end
               default: ; // status and unmapped writes are ignored
            endcase
         end else begin
            unique case (wb_adr_i)
               fpa_pkg::REG_CFG: st_next.rdata = {29'h00000000, st_reg.cfg};
               fpa_pkg::REG_ISO_LIMIT: st_next.rdata = {24'h000000, st_reg.iso_limit};
               fpa_pkg::REG_STATUS: begin
                  st_next.rdata[fpa_pkg::ST_LEDS +: 7] = st_reg.leds;
                  st_next.rdata[fpa_pkg::ST_FAULT_SND] = st_reg.fault_snd;
                  st_next.rdata[fpa_pkg::ST_FAULT_TEXT] = st_reg.fault_text;
                  st_next.rdata[fpa_pkg::ST_ALARM_SND] = alarm_sounder_o;
                  st_next.rdata[fpa_pkg::ST_BATT_RUN] = batt_running;
                  st_next.rdata[fpa_pkg::ST_BATT_FAIL] = batt_failed;
               end
               default: st_next.rdata = 32'h00000000;
            endcase
         end
      end
   end

   // ==========================================================
   // state register; clock enable freezes everything
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         // configuration and limit come up at their power-on values
         st_reg.cfg <= fpa_pkg::CFG_RESET;
         st_reg.iso_limit <= fpa_pkg::ISO_LIMIT_RESET;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // outputs; alarm sounder pulses while unacknowledged and not silenced
   assign wb_ack_o = st_reg.ack;
   assign wb_dat_o = st_reg.rdata;
   assign leds_o = st_reg.leds;
   assign fault_sounder_o = st_reg.fault_snd;
   assign fault_text_o = st_reg.fault_text;
   assign alarm_next_o = st_reg.next_pulse;
   // combinational so the tone tracks the list state with no extra lag
   assign alarm_sounder_o = list_unack_i && !st_reg.alarm_sil && flash.norm;
endmodule : fpa_annunciator

// ==== verification/fpa_annunciator_asserts.sv ====
// checker for the status annunciator ports
`timescale 1ns/1ps
module fpa_annunciator_asserts #(
   parameter int unsigned NZ = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // status inputs
   input wire logic [NZ-1:0] zone_fault_i,
   input wire logic mains_ok_i,
   input wire logic charger_fault_i,
   input wire logic batt_low_i,
   input wire logic system_fault_i,
   input wire logic db_download_i,
   input wire logic list_unack_i,
   input wire logic bells_local_iso_i,
   input wire logic bells_remote_silenced_i,
   input wire logic bells_ext_silenced_i,
   // keys
   input wire logic key_clear_i,
   input wire logic key_ack_i,
   input wire logic key_next_i,
   // outputs
   input fpa_pkg::fpa_leds_type leds_o,
   input wire logic fault_sounder_o,
   input wire logic fault_text_o,
   input wire logic alarm_sounder_o,
   input wire logic alarm_next_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================
   // bus handshake
   AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   AST_WB_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   // ==========================================
   // indicators and sounder
   AST_FAULT_LED: assert property (1 |=> leds_o.fault == $past(|zone_fault_i))
      else $error("fault led does not follow zone faults");
   AST_MAINS_OFF: assert property (!mains_ok_i [*2] |-> !leds_o.mains)
      else $error("mains led lit without mains");
   AST_SILENCE: assert property ((key_clear_i || key_ack_i) && $stable(zone_fault_i)
      && $stable(charger_fault_i) && $stable(system_fault_i) && $stable(batt_low_i)
      |=> !fault_sounder_o && !fault_text_o) else $error("silence key ignored");
   AST_SYS_FAULT: assert property ($rose(system_fault_i) && !db_download_i |=> leds_o.sysflt)
      else $error("system fault led not lit");
   AST_NEXT_KEY: assert property (key_next_i && !$rose(list_unack_i)
      |=> alarm_next_o && !alarm_sounder_o) else $error("next key not acted on");
   AST_BELLS: assert property (!bells_remote_silenced_i && !bells_ext_silenced_i
      |=> leds_o.bells == $past(bells_local_iso_i)) else $error("bells led wrong");
endmodule : fpa_annunciator_asserts

bind fpa_annunciator fpa_annunciator_asserts #(.NZ(NZ)) i_fpa_annunciator_asserts (.*);

// ==== verification/fpa_keypad_model.sv ====
// operator keypad model: one-cycle key presses
`timescale 1ns/1ps
module fpa_keypad_model (
   // clock
   input wire logic clk_i,
   // keys
   output logic key_clear_o,
   output logic key_ack_o,
   output logic key_next_o
);
   initial begin
      key_clear_o = 1'b0;
      key_ack_o = 1'b0;
      key_next_o = 1'b0;
   end
   // ==========================================
   // press: 0 clear, 1 ack, 2 or more next; held one edge only
   task automatic press(input int k);
      @(posedge clk_i);
      key_clear_o <= (k == 0);
      key_ack_o <= (k == 1);
      key_next_o <= (k > 1);
      @(posedge clk_i);
      key_clear_o <= 1'b0;
      key_ack_o <= 1'b0;
      key_next_o <= 1'b0;
   endtask : press
endmodule : fpa_keypad_model

// ==== verification/tb_fpa_annunciator.sv ====
// self-checking bench for the status annunciator
`timescale 1ns/1ps
module tb_fpa_annunciator;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [7:0] zone_alarm_i = 8'h00, zone_master_alarm_group_i = 8'h00;
   logic [7:0] zone_fault_i = 8'h00, zone_isolated_i = 8'h00;
   logic point_isolated_i = 1'b0, list_unack_i = 1'b0, group_unplaced_unack_i = 1'b0;
   logic mains_ok_i = 1'b1, charger_fault_i = 1'b0, batt_low_i = 1'b0;
   logic batt_disconnected_i = 1'b0, batt_test_start_i = 1'b0;
   logic batt_test_done_i = 1'b0, batt_test_pass_i = 1'b0;
   logic system_fault_i = 1'b0, db_download_i = 1'b0, key_base_display_i = 1'b1;
   logic bells_local_iso_i = 1'b0, bells_remote_silenced_i = 1'b0;
   logic bells_ext_silenced_i = 1'b0, key_clear_i, key_ack_i, key_next_i;
   logic fault_sounder_o, alarm_sounder_o, fault_text_o, alarm_next_o;
   fpa_pkg::fpa_leds_type leds_o;
   int fail_count = 0, n_compared = 0, hi, rs;

   // short tick (10 cycles) and hold (5 ticks) keep flash checks brief
   fpa_annunciator #(.TICK_CYC(10), .HOLD_TICKS(5)) i_fpa_annunciator (.*);
   fpa_keypad_model i_fpa_keypad_model (.clk_i(clk_i), .key_clear_o(key_clear_i),
      .key_ack_o(key_ack_i), .key_next_o(key_next_i));

   always #2 clk_i = ~clk_i;

   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // led bits: 0 alarm 1 fault 2 isolate 3 mains 4 charger 5 sysflt 6 bells
   task automatic lchk(input int b, input logic e);
      chk({31'h0, leds_o[b]}, {31'h0, e});
   endtask : lchk
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask : step
   // classic cycle: hold until ack is sampled high, then release
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 20) fail_count++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   // count high samples and rising edges of one led
   task automatic meas(input int b, input int n);
      logic p;
      hi = 0;
      rs = 0;
      p = leds_o[b];
      repeat (n) begin
         @(posedge clk_i);
         hi += int'(leds_o[b]);
         if (leds_o[b] && !p) rs++;
         p = leds_o[b];
      end
   endtask : meas
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up

   // watchdog: run needs about 4100 cycles
   initial begin
      step(20000);
      fail_count++;
      wrap_up();
   end

   // ==========================================
   // main sequence
   initial begin
      step(2);
      rst_i <= 1'b0;
      wb(1'b0, 4'h0, 32'h0); chk(rd, 32'h5);
      wb(1'b0, 4'h4, 32'h0); chk(rd, 32'hFF);
      wb(1'b1, 4'hC, 32'h3); chk(rd, 32'h0);
      wb(1'b1, 4'h4, 32'h2);
      mains_ok_i <= 1'b0; step(2); lchk(3, 1'b0);
      wb(1'b0, 4'h8, 32'h0); chk(rd & 32'h7F, 32'h0);
      mains_ok_i <= 1'b1; charger_fault_i <= 1'b1; step(2);
      meas(4, 100); chk(hi, 100);
      // sounder, text and silence keys
      zone_fault_i <= 8'h08; step(2);
      chk({29'h0, fault_sounder_o, fault_text_o, leds_o.fault}, 32'h7);
      i_fpa_keypad_model.press(1); step(1);
      chk({30'h0, fault_sounder_o, fault_text_o}, 32'h0);
      zone_fault_i <= 8'h28; step(2); chk({31'h0, fault_sounder_o}, 32'h1);
      i_fpa_keypad_model.press(0); step(1);
      chk({30'h0, fault_sounder_o, fault_text_o}, 32'h0);
      // away from base display a new fault sounds but shows no text
      key_base_display_i <= 1'b0; zone_fault_i <= 8'h29; step(2);
      chk({30'h0, fault_sounder_o, fault_text_o}, 32'h2);
      key_base_display_i <= 1'b1;
      wb(1'b1, 4'h0, 32'h6);
      system_fault_i <= 1'b1; step(2);
      chk({30'h0, fault_sounder_o, leds_o.sysflt}, 32'h1);
      db_download_i <= 1'b1; step(2); meas(5, 400);
      chk(rs, 1); chk(hi, 200);
      db_download_i <= 1'b0; system_fault_i <= 1'b0; charger_fault_i <= 1'b0;
      // isolates against the zone limit of two
      zone_isolated_i <= 8'h04; step(2); lchk(2, 1'b0);
      zone_isolated_i <= 8'h06; step(2); lchk(2, 1'b1);
      point_isolated_i <= 1'b1; step(2); meas(2, 400); chk(rs, 4);
      // alarm qualification by group setting, isolated zone 1
      wb(1'b1, 4'h0, 32'h1); zone_alarm_i <= 8'h02; step(2); lchk(0, 1'b0);
      zone_master_alarm_group_i <= 8'h02; step(2); lchk(0, 1'b1);
      zone_master_alarm_group_i <= 8'h00; wb(1'b1, 4'h0, 32'h6); step(2); lchk(0, 1'b1);
      list_unack_i <= 1'b1; step(2); meas(0, 400); chk(rs, 4);
      // internal sounder pulses with the normal flash until next is pressed
      hi = 0;
      repeat (100) begin
         @(posedge clk_i);
         hi += int'(alarm_sounder_o);
      end
      chk(hi, 50);
      i_fpa_keypad_model.press(2); step(1);
      chk({30'h0, alarm_next_o, alarm_sounder_o}, 32'h2);
      list_unack_i <= 1'b0; zone_alarm_i <= 8'h00;
      // group alarm that could not be listed also flashes the alarm led
      group_unplaced_unack_i <= 1'b1; step(2); meas(0, 400); chk(rs, 4);
      group_unplaced_unack_i <= 1'b0;
      // bells indicator by silence source
      bells_local_iso_i <= 1'b1; step(2); lchk(6, 1'b1);
      bells_remote_silenced_i <= 1'b1; step(2); meas(6, 400); chk(rs, 1);
      bells_ext_silenced_i <= 1'b1; step(2); meas(6, 400); chk(rs, 4);
      chk(hi, 200);
      // battery test: run, fail, hold expiry, pass
      batt_test_start_i <= 1'b1; step(1); batt_test_start_i <= 1'b0; step(2);
      meas(4, 400); chk(rs, 10); chk(hi, 200);
      batt_test_done_i <= 1'b1; step(1); batt_test_done_i <= 1'b0; step(2);
      wb(1'b0, 4'h8, 32'h0); chk({30'h0, rd[11:10]}, 32'h2);
      step(200); lchk(4, 1'b0);
      batt_test_start_i <= 1'b1; step(1); batt_test_start_i <= 1'b0; step(5);
      batt_test_pass_i <= 1'b1; batt_test_done_i <= 1'b1; step(1);
      batt_test_done_i <= 1'b0; step(2); lchk(4, 1'b0);
      batt_low_i <= 1'b1; step(2); meas(4, 400); chk(rs, 4);
      batt_low_i <= 1'b0; batt_disconnected_i <= 1'b1; step(2);
      meas(4, 400); chk(rs, 4);
      wrap_up();
   end
endmodule : tb_fpa_annunciator
